// >>> dsli_top.v
// front panel status lamp driver with avalon register slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dsli_regs.vh"

module dsli_top #(
   parameter TICK_CYCLES = `DSLI_TICK_CYCLES
) (
   input  wire        clk,
   input  wire        nrst,
   // avalon-mm slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output wire        irq,
   // supply sense pins
   input  wire        main_supply_on,
   input  wire        ctrl_supply_on,
   // drive status logic
   input  wire        alarm_active,
   input  wire [4:0]  alarm_code,
   input  wire        info_pending,
   input  wire        remote_op_active,
   input  wire        sim_mode,
   // fieldbus slave controller
   input  wire [3:0]  bus_state,
   input  wire [1:0]  comm_err_class,
   input  wire        link_up,
   input  wire        link_traffic,
   // lamps
   output reg         supply_fault_lamp_green,
   output reg         supply_fault_lamp_red,
   output reg         supply_fault_lamp_blue,
   output reg         state_lamp,
   output reg         fault_lamp,
   output reg         link_lamp
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   reg  [3:0]              sync1_reg;
   reg  [3:0]              sync2_reg;
   reg  [1:0]              ctrl_reg;
   reg  [`DSLI_EV_W-1:0]   irq_stat_reg;
   reg  [`DSLI_EV_W-1:0]   irq_mask_reg;
   reg                     ack_reg;
   reg  [5:0]              alm_cnt_reg;
   reg  [5:0]              alm_cnt_next;
   reg  [3:0]              sim_div_reg;
   reg  [1:0]              sim_step_reg;
   reg                     alarm_d_reg;
   reg                     info_d_reg;
   reg                     err_d_reg;
   reg                     link_d_reg;
   reg                     green_next;
   reg                     red_next;
   reg                     blue_next;
   reg                     state_next;
   reg                     fault_next;
   reg                     link_next;
   reg  [31:0]             rd_mux;
   wire                    main_on;
   wire                    ctrl_on;
   wire                    link_ok;
   wire                    traffic;
   wire                    tick;
   wire                    blink;
   wire                    flicker;
   wire                    flash1;
   wire                    flash2;
   wire                    period_end;
   wire                    lamps_en;
   wire                    lamp_test;
   wire                    bus_req;
   wire                    wr_take;
   wire                    rd_take;
   wire                    wr_lo;
   wire [`DSLI_EV_W-1:0]   events;
   wire [`DSLI_EV_W-1:0]   w1c;
   wire [5:0]              alm_burst_len;
   wire                    comm_err;

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for pin-level inputs
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync2_reg[gi] <= sync1_reg[gi];
               case (gi)
                  0:       sync1_reg[gi] <= main_supply_on;
                  1:       sync1_reg[gi] <= ctrl_supply_on;
                  2:       sync1_reg[gi] <= link_up;
                  default: sync1_reg[gi] <= link_traffic;
               endcase
            end
         end
      end
   endgenerate

   assign main_on = sync2_reg[0];
   assign ctrl_on = sync2_reg[1];
   assign link_ok = sync2_reg[2];
   assign traffic = sync2_reg[3];

   ////////////////////////////////////////////////////////////////////////
   // shared timebase
   dsli_timebase #(
      .TICK_CYCLES      (TICK_CYCLES)
   ) u_timebase (
      .clk              (clk),
      .nrst             (nrst),
      .tick             (tick),
      .blink            (blink),
      .flicker          (flicker),
      .flash1           (flash1),
      .flash2           (flash2),
      .blink_period_end (period_end)
   );

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle on every access
   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack_reg;
   assign wr_take         = avs_write & ack_reg;
   assign rd_take         = avs_read & ~ack_reg;
   assign wr_lo           = wr_take & avs_byteenable[0];
   assign lamps_en        = ctrl_reg[`DSLI_CTRL_EN_BIT];
   assign lamp_test       = ctrl_reg[`DSLI_CTRL_TEST_BIT];

   always @* begin
      rd_mux = 32'h00000000;
      case (avs_address)
         `DSLI_OFS_CTRL:     rd_mux[1:0] = ctrl_reg;
         `DSLI_OFS_STATUS:   rd_mux[15:0] = {bus_state, comm_err_class,
                                link_ok, traffic, main_on, ctrl_on,
                                link_lamp, fault_lamp, state_lamp,
                                supply_fault_lamp_blue,
                                supply_fault_lamp_red,
                                supply_fault_lamp_green};
         `DSLI_OFS_IRQ_STAT: rd_mux[`DSLI_EV_W-1:0] = irq_stat_reg;
         `DSLI_OFS_IRQ_MASK: rd_mux[`DSLI_EV_W-1:0] = irq_mask_reg;
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_reg      <= 1'b0;
         avs_readdata <= 32'h00000000;
         ctrl_reg     <= `DSLI_CTRL_RESET;
         irq_mask_reg <= {`DSLI_EV_W{1'b0}};
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (rd_take)
            avs_readdata <= rd_mux;
         if (wr_lo && avs_address == `DSLI_OFS_CTRL)
            ctrl_reg <= avs_writedata[1:0];
         if (wr_lo && avs_address == `DSLI_OFS_IRQ_MASK)
            irq_mask_reg <= avs_writedata[`DSLI_EV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt events: rising alarm, info, comm error; link change
   assign comm_err = (comm_err_class != `DSLI_ERR_NONE);
   assign events[`DSLI_EV_ALARM]    = alarm_active & ~alarm_d_reg;
   assign events[`DSLI_EV_INFO]     = info_pending & ~info_d_reg;
   assign events[`DSLI_EV_COMM_ERR] = comm_err & ~err_d_reg;
   assign events[`DSLI_EV_LINK]     = link_ok ^ link_d_reg;
   assign w1c = (wr_lo && avs_address == `DSLI_OFS_IRQ_STAT) ?
                avs_writedata[`DSLI_EV_W-1:0] : {`DSLI_EV_W{1'b0}};
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarm_d_reg  <= 1'b0;
         info_d_reg   <= 1'b0;
         err_d_reg    <= 1'b0;
         link_d_reg   <= 1'b0;
         irq_stat_reg <= {`DSLI_EV_W{1'b0}};
      end else begin
         alarm_d_reg  <= alarm_active;
         info_d_reg   <= info_pending;
         err_d_reg    <= comm_err;
         link_d_reg   <= link_ok;
         // set wins over clear
         irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm burst: code blinks, then a dark gap of three periods
   // one bit wider so that the top alarm codes do not wrap
   assign alm_burst_len = {1'b0, alarm_code} + {1'b0, `DSLI_ALM_GAP};

   always @* begin
      alm_cnt_next = alm_cnt_reg;
      if (!alarm_active)
         alm_cnt_next = 6'h00;
      else if (period_end) begin
         if (alm_cnt_reg >= alm_burst_len - 6'h01)
            alm_cnt_next = 6'h00;
         else
            alm_cnt_next = alm_cnt_reg + 6'h01;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         alm_cnt_reg <= 6'h00;
      else
         alm_cnt_reg <= alm_cnt_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // simulation colour sequence, 500 ms per step
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sim_div_reg  <= 4'h0;
         sim_step_reg <= `DSLI_SIM_GREEN;
      end else if (!sim_mode) begin
         sim_div_reg  <= 4'h0;
         sim_step_reg <= `DSLI_SIM_GREEN;
      end else if (tick) begin
         if (sim_div_reg == `DSLI_SIM_STEP_LAST) begin
            sim_div_reg  <= 4'h0;
            sim_step_reg <= sim_step_reg + 2'h1;
         end else begin
            sim_div_reg <= sim_div_reg + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // supply/fault lamp colour with priority
   always @* begin
      green_next = 1'b0;
      red_next   = 1'b0;
      blue_next  = 1'b0;
      if (sim_mode) begin
         case (sim_step_reg)
            `DSLI_SIM_GREEN: green_next = 1'b1;
            `DSLI_SIM_RED:   red_next   = 1'b1;
            `DSLI_SIM_BOTH: begin
               green_next = 1'b1;
               red_next   = 1'b1;
            end
            default: green_next = 1'b0;
         endcase
      end else if (alarm_active) begin
         red_next = blink & (alm_cnt_reg < alarm_code);
      end else if (info_pending | remote_op_active) begin
         blue_next = blink;
      end else begin
         green_next = main_on | ctrl_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fieldbus lamps
   always @* begin
      case (bus_state)
         `DSLI_ST_PREOP:  state_next = blink;
         `DSLI_ST_SAFEOP: state_next = flash1;
         `DSLI_ST_OP:     state_next = 1'b1;
         default:         state_next = 1'b0;
      endcase
      // only the fieldbus error class reaches this lamp
      case (comm_err_class)
         `DSLI_ERR_SETTING:  fault_next = blink;
         `DSLI_ERR_DATA:     fault_next = flash1;
         `DSLI_ERR_WATCHDOG: fault_next = flash2;
         default:            fault_next = 1'b0;
      endcase
      link_next = link_ok & (traffic ? flicker : 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////
   // lamp output registers, gated by enable, forced by test
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         supply_fault_lamp_green <= 1'b0;
         supply_fault_lamp_red   <= 1'b0;
         supply_fault_lamp_blue  <= 1'b0;
         state_lamp              <= 1'b0;
         fault_lamp              <= 1'b0;
         link_lamp               <= 1'b0;
      end else begin
         supply_fault_lamp_green <= lamp_test | (lamps_en & green_next);
         supply_fault_lamp_red   <= lamp_test | (lamps_en & red_next);
         supply_fault_lamp_blue  <= lamp_test | (lamps_en & blue_next);
         state_lamp              <= lamp_test | (lamps_en & state_next);
         fault_lamp              <= lamp_test | (lamps_en & fault_next);
         link_lamp               <= lamp_test | (lamps_en & link_next);
      end
   end

endmodule // dsli_top

// >>> dsli_regs.vh
// constants, register map and timing of the status lamp driver
// Notes on behaviour
// - supply present and nothing else active gives steady green.
// - active alarm blinks red in bursts; blink count equals alarm code.
// - alarm reset stops red blinking and returns steady green.
// - pending information blinks blue; clearing it returns steady green.
// - remote operation blinks blue; its end returns steady green.
// - simulation mode cycles green, red, both, dark repeatedly.
// - state lamp dark Init, blink PreOp, single flash SafeOp, lit Op.
// - fault lamp dark, blink setting, single data, double watchdog error.
// - link lamp dark without link, lit with link, flicker on traffic.
// - fault lamp shows fieldbus communication errors only, never drive alarms.
`ifndef DSLI_REGS_VH
`define DSLI_REGS_VH

// register byte offsets
`define DSLI_OFS_CTRL      4'h0
`define DSLI_OFS_STATUS    4'h4
`define DSLI_OFS_IRQ_STAT  4'h8
`define DSLI_OFS_IRQ_MASK  4'hC

// control register fields
`define DSLI_CTRL_EN_BIT   0
`define DSLI_CTRL_TEST_BIT 1
`define DSLI_CTRL_RESET    2'h1

// interrupt event bits
`define DSLI_EV_ALARM      0
`define DSLI_EV_INFO       1
`define DSLI_EV_COMM_ERR   2
`define DSLI_EV_LINK       3
`define DSLI_EV_W          4

// fieldbus state codes
`define DSLI_ST_INIT       4'h1
`define DSLI_ST_PREOP      4'h2
`define DSLI_ST_SAFEOP     4'h4
`define DSLI_ST_OP         4'h8

// communication error classes
`define DSLI_ERR_NONE      2'h0
`define DSLI_ERR_SETTING   2'h1
`define DSLI_ERR_DATA      2'h2
`define DSLI_ERR_WATCHDOG  2'h3

// timebase: one tick every 50 ms at 20 MHz
`define DSLI_CLK_KHZ       20000
`define DSLI_TICK_MS       50
`define DSLI_TICK_CYCLES   (`DSLI_TICK_MS * `DSLI_CLK_KHZ)

// pattern lengths in ticks, alarm gap in blink periods
`define DSLI_FRAME_TICKS   5'h18
`define DSLI_FRAME_LAST    5'h17
`define DSLI_BLINK_HALF    5'h04
`define DSLI_FLASH2_START  5'h08
`define DSLI_FLASH2_END    5'h0C
`define DSLI_SIM_STEP_LAST 4'h9
`define DSLI_ALM_GAP       5'h03

// simulation colour steps
`define DSLI_SIM_GREEN     2'h0
`define DSLI_SIM_RED       2'h1
`define DSLI_SIM_BOTH      2'h2
`define DSLI_SIM_DARK      2'h3

`endif

// >>> dsli_timebase.v
// shared lamp timebase and pattern generator
`timescale 1ns/1ps
`include "dsli_regs.vh"

module dsli_timebase #(
   parameter TICK_CYCLES = `DSLI_TICK_CYCLES
) (
   input  wire       clk,
   input  wire       nrst,
   output wire       tick,
   output reg        blink,
   output reg        flicker,
   output reg        flash1,
   output reg        flash2,
   output wire       blink_period_end
);

   reg  [19:0] div_reg;
   reg  [4:0]  phase_reg;
   wire        div_last;
   wire [2:0]  blink_pos;

   assign div_last         = (div_reg == TICK_CYCLES - 1);
   assign tick             = div_last;
   assign blink_pos        = phase_reg[2:0];
   assign blink_period_end = div_last & (blink_pos == 3'h7);

   ////////////////////////////////////////////////////////////////////////
   // tick divider and frame phase, shared by every pattern
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_reg   <= 20'h00000;
         phase_reg <= 5'h00;
      end else begin
         if (div_last) begin
            div_reg <= 20'h00000;
            if (phase_reg == `DSLI_FRAME_LAST)
               phase_reg <= 5'h00;
            else
               phase_reg <= phase_reg + 5'h01;
         end else begin
            div_reg <= div_reg + 20'h00001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pattern levels: 200 ms blink, 50 ms flicker, 200 ms flashes
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blink   <= 1'b0;
         flicker <= 1'b0;
         flash1  <= 1'b0;
         flash2  <= 1'b0;
      end else begin
         blink   <= ({2'h0, blink_pos} < `DSLI_BLINK_HALF);
         flicker <= phase_reg[0];
         flash1  <= (phase_reg < `DSLI_BLINK_HALF);
         flash2  <= (phase_reg < `DSLI_BLINK_HALF) |
                    ((phase_reg >= `DSLI_FLASH2_START) &
                     (phase_reg < `DSLI_FLASH2_END));
      end
   end

endmodule // dsli_timebase

// >>> dsli_checker.sv
// assertion checker for the status lamp driver
`timescale 1ns/1ps
`include "dsli_regs.vh"

module dsli_checker #(
   parameter TICK_CYCLES = 4
) (
   input wire        clk,
   input wire        nrst,
   input wire [3:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire        avs_waitrequest,
   input wire        main_supply_on,
   input wire        alarm_active,
   input wire        info_pending,
   input wire        remote_op_active,
   input wire        sim_mode,
   input wire [3:0]  bus_state,
   input wire [1:0]  comm_err_class,
   input wire        link_up,
   input wire        link_traffic,
   input wire        supply_fault_lamp_green,
   input wire        supply_fault_lamp_red,
   input wire        supply_fault_lamp_blue,
   input wire        state_lamp,
   input wire        fault_lamp,
   input wire        link_lamp
);
   reg  en_reg;
   reg  test_reg;
   wire ctrl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
                  avs_address == `DSLI_OFS_CTRL;
   wire norm = en_reg && !test_reg;
   wire quiet = !(alarm_active || info_pending || remote_op_active || sim_mode);

   // shadow of lamp enable and lamp test
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         en_reg   <= 1'b1;
         test_reg <= 1'b0;
      end else if (ctrl_wr) begin
         en_reg   <= avs_writedata[0];
         test_reg <= avs_writedata[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence req_wait_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence req_ack_s;
      !avs_waitrequest;
   endsequence

   one_wait_a: assert property (req_wait_s |=> req_ack_s)
      else $error("waitrequest held beyond one cycle");
   idle_nowait_a: assert property (!(avs_read || avs_write) |-> req_ack_s)
      else $error("waitrequest without a request");
   steady_green_a: assert property ((main_supply_on && quiet && norm)[*4] |->
      supply_fault_lamp_green && !supply_fault_lamp_red &&
      !supply_fault_lamp_blue) else $error("lamp not steady green");
   sim_blue_a: assert property ((sim_mode && norm)[*2] |->
      !supply_fault_lamp_blue) else $error("blue during simulation");
   alarm_prio_a: assert property ((alarm_active && !sim_mode && norm)[*2]
      |-> !supply_fault_lamp_blue && !supply_fault_lamp_green)
      else $error("alarm not shown in red alone");
   blue_cause_a: assert property
      ((!info_pending && !remote_op_active && norm)[*2] |->
      !supply_fault_lamp_blue) else $error("blue without a cause");
   fault_quiet_a: assert property
      ((comm_err_class == `DSLI_ERR_NONE && norm)[*2] |-> !fault_lamp)
      else $error("fault lamp lit without error");
   state_init_a: assert property
      ((bus_state == `DSLI_ST_INIT && norm)[*2] |-> !state_lamp)
      else $error("state lamp lit in init");
   state_op_a: assert property
      ((bus_state == `DSLI_ST_OP && norm)[*2] |-> state_lamp)
      else $error("state lamp dark in operational");
   link_dark_a: assert property ((!link_up && norm)[*4] |-> !link_lamp)
      else $error("link lamp lit without link");
   link_lit_a: assert property
      ((link_up && !link_traffic && norm)[*4] |-> link_lamp)
      else $error("link lamp dark on idle link");
endmodule // dsli_checker

bind dsli_top dsli_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
   .clk(clk), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_waitrequest(avs_waitrequest), .main_supply_on(main_supply_on),
   .alarm_active(alarm_active), .info_pending(info_pending),
   .remote_op_active(remote_op_active), .sim_mode(sim_mode),
   .bus_state(bus_state), .comm_err_class(comm_err_class),
   .link_up(link_up), .link_traffic(link_traffic),
   .supply_fault_lamp_green(supply_fault_lamp_green),
   .supply_fault_lamp_red(supply_fault_lamp_red),
   .supply_fault_lamp_blue(supply_fault_lamp_blue),
   .state_lamp(state_lamp), .fault_lamp(fault_lamp), .link_lamp(link_lamp));

// >>> dsli_operator.sv
// panel observer counting lamp on-cycles and lighting edges
`timescale 1ns/1ps

module dsli_operator (
   input  wire        clk,
   input  wire        clr,
   input  wire [7:0]  lamps,
   output logic [10:0] on_cnt [0:7],
   output logic [10:0] rise_cnt [0:7]
);
   reg [7:0] prev_reg;
   integer   i;

   always @(posedge clk) begin
      prev_reg <= lamps;
      for (i = 0; i < 8; i = i + 1) begin
         if (clr) begin
            on_cnt[i]   <= 11'h000;
            rise_cnt[i] <= 11'h000;
         end else begin
            on_cnt[i]   <= on_cnt[i] + {10'h000, lamps[i]};
            rise_cnt[i] <= rise_cnt[i] + {10'h000, lamps[i] & ~prev_reg[i]};
         end
      end
   end
endmodule // dsli_operator

// >>> tb.sv
// self-checking bench for the status lamp driver
`timescale 1ns/1ps
`include "dsli_regs.vh"

module tb;
   localparam T   = 4;
   localparam FL  = `DSLI_BLINK_HALF * T;
   localparam BLK = 2 * FL;
   localparam FRM = `DSLI_FRAME_TICKS * T;
   localparam SIM = (`DSLI_SIM_STEP_LAST + 1) * T;
   reg         clk = 0, nrst = 0, rd = 0, wr = 0, clr = 0;
   reg         mon = 0, con = 0, alm = 0, info = 0, rem = 0;
   reg         sim = 0, lup = 0, ltr = 0;
   reg  [3:0]  adr = 4'h0, be = 4'h0, bst = `DSLI_ST_INIT;
   reg  [31:0] wd = 32'h0, q;
   reg  [4:0]  code = 5'h00;
   reg  [1:0]  err = `DSLI_ERR_NONE;
   wire [31:0] rdat;
   wire        wreq, irq, g, r, b, st, fl, lk;
   wire [10:0] on_c [0:7];
   wire [10:0] rs_c [0:7];
   integer     n_fail = 0, cmp_count = 0, cyc = 0, j;

   dsli_top #(.TICK_CYCLES(T)) dut_u (
      .clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq),
      .main_supply_on(mon), .ctrl_supply_on(con), .alarm_active(alm),
      .alarm_code(code), .info_pending(info), .remote_op_active(rem),
      .sim_mode(sim), .bus_state(bst), .comm_err_class(err),
      .link_up(lup), .link_traffic(ltr), .supply_fault_lamp_green(g),
      .supply_fault_lamp_red(r), .supply_fault_lamp_blue(b),
      .state_lamp(st), .fault_lamp(fl), .link_lamp(lk));
   dsli_operator op_u (.clk(clk), .clr(clr),
      .lamps({~(g | r | b), g & r, lk, fl, st, b, r, g}),
      .on_cnt(on_c), .rise_cnt(rs_c));

   initial begin
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // waitrequest judged at each edge; only the bench timeout ends a hang
   task automatic xfer(input w, input [3:0] a, input [31:0] d,
                       input [3:0] e);
      begin
         @(posedge clk);
         adr <= a;
         wd <= d;
         be <= e;
         wr <= w;
         rd <= !w;
         @(posedge clk);
         while (wreq !== 1'b0)
            @(posedge clk);
         q = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask

   // settle, then count lamp activity over n cycles
   task automatic watch(input integer n);
      begin
         repeat (6) @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (n + 1) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      begin
         xfer(0, `DSLI_OFS_CTRL, 32'h0, 4'hF);
         check(q, `DSLI_CTRL_RESET);
         xfer(0, `DSLI_OFS_STATUS, 32'h0, 4'hF);
         check(q, 32'h00001000);
         xfer(0, `DSLI_OFS_IRQ_MASK, 32'h0, 4'hF);
         check(q, 32'h0);
         xfer(1, `DSLI_OFS_IRQ_MASK, 32'hFFFFFFFF, 4'hF);
         xfer(1, `DSLI_OFS_IRQ_MASK, 32'h0, 4'h0);
         xfer(0, `DSLI_OFS_IRQ_MASK, 32'h0, 4'hF);
         check(q, 32'hF);
         xfer(1, 4'h2, 32'hFFFFFFFF, 4'hF);
         xfer(0, 4'h2, 32'h0, 4'hF);
         check(q, 32'h0);
         xfer(1, `DSLI_OFS_IRQ_MASK, 32'h0, 4'hF);
      end
   endtask

   task automatic t_supply;
      for (j = 0; j < 4; j = j + 1) begin
         mon <= j[0];
         con <= j[1];
         watch(FRM);
         check(on_c[0], (j == 0) ? 0 : FRM);
         check(on_c[1] + on_c[2], 0);
      end
   endtask

   task automatic t_alarm;
      begin
         code <= 5'h01;
         alm <= 1'b1;
         repeat (6) @(posedge clk);
         check(irq, 1'b0);
         xfer(0, `DSLI_OFS_IRQ_STAT, 32'h0, 4'hF);
         check(q, 32'h1);
         xfer(1, `DSLI_OFS_IRQ_MASK, 32'h1, 4'hF);
         @(posedge clk);
         check(irq, 1'b1);
         xfer(1, `DSLI_OFS_IRQ_STAT, 32'h1, 4'hF);
         @(posedge clk);
         check(irq, 1'b0);
         for (j = 1; j < 5; j = j + 3) begin
            alm <= 1'b0;
            repeat (4) @(posedge clk);
            code <= j[4:0];
            alm <= 1'b1;
            repeat (BLK * 8) @(posedge clk);
            watch((j + `DSLI_ALM_GAP) * BLK * 2);
            check(rs_c[1], 2 * j);
            check(on_c[4] + on_c[2], 0);
         end
         alm <= 1'b0;
         watch(FRM);
         check(on_c[0], FRM);
         check(on_c[1], 0);
      end
   endtask

   task automatic t_blue;
      for (j = 0; j < 2; j = j + 1) begin
         info <= (j == 0);
         rem <= (j == 1);
         watch(BLK * 4);
         check(rs_c[2], 4);
         check(on_c[2], BLK * 2);
         info <= 1'b0;
         rem <= 1'b0;
         watch(BLK);
         check(on_c[0] - on_c[2], BLK);
      end
   endtask

   task automatic t_sim;
      begin
         sim <= 1'b1;
         alm <= 1'b1;
         info <= 1'b1;
         watch(4 * SIM);
         check(on_c[0], 2 * SIM);
         check(on_c[1], 2 * SIM);
         check(on_c[6], SIM);
         check(on_c[7], SIM);
         sim <= 1'b0;
         alm <= 1'b0;
         info <= 1'b0;
      end
   endtask

   task automatic t_fbus;
      for (j = 0; j < 4; j = j + 1) begin
         bst <= 4'h1 << j;
         err <= j[1:0];
         watch(FRM);
         check(on_c[3], (j == 0) ? 0 : (j == 1) ? FRM / 2 :
                        (j == 2) ? FL : FRM);
         check(on_c[4], (j == 0) ? 0 : (j == 1) ? FRM / 2 :
                        (j == 2) ? FL : 2 * FL);
         check(rs_c[4], (j == 1) ? FRM / BLK : (j == 0) ? 0 : j - 1);
      end
   endtask

   task automatic t_link;
      for (j = 0; j < 3; j = j + 1) begin
         lup <= (j > 0);
         ltr <= (j == 2);
         watch(FRM);
         check(on_c[5], (j == 0) ? 0 : (j == 1) ? FRM : FRM / 2);
         check(rs_c[5], (j == 2) ? FRM / (2 * T) : 0);
      end
   endtask

   task automatic t_ctrl;
      begin
         xfer(1, `DSLI_OFS_CTRL, 32'h0, 4'h1);
         watch(FL);
         check(on_c[0] + on_c[3] + on_c[4] + on_c[5], 0);
         xfer(1, `DSLI_OFS_CTRL, 32'h3, 4'h1);
         watch(FL);
         check(on_c[0] + on_c[1] + on_c[2] + on_c[3] + on_c[4] + on_c[5],
               6 * FL);
         xfer(1, `DSLI_OFS_CTRL, 32'h1, 4'h1);
      end
   endtask

   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_supply;
      t_alarm;
      t_blue;
      t_sim;
      t_fbus;
      t_link;
      t_ctrl;
      final_report;
   end
endmodule // tb
